// *** scsi_host_model.sv ***
// initiator model: paced write source and paced read sink
// assumes the bench sets limit, gap and rd_go just after a clock edge
`timescale 1ns/1ns
module scsi_host_model
  import tape_buffer_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [15:0] limit,
  input  wire logic [3:0]  gap,
  input  wire logic        rd_go,
  input  wire logic        host_wr_ready,
  output byte_beat_s       host_wr,
  output logic             host_more,
  output logic             host_rd_ready,
  output logic [15:0]      n_sent
);
  logic       taken;
  logic [3:0] wait_cnt;
  logic [3:0] rd_cnt;

  initial
  begin
    host_wr = '0;
    host_more = 1'b0;
    host_rd_ready = 1'b0;
    n_sent = '0;
    wait_cnt = '0;
    rd_cnt = '0;
  end

  // ==========================================================================
  // pacing: gap idle cycles after each byte, zero gives full rate
  // ==========================================================================
  always @(negedge ref_clk)
  begin
    taken = host_wr.valid && host_wr_ready;
    @(posedge ref_clk);
    #1;
    if (taken)
    begin
      n_sent = n_sent + 16'h0001;
      wait_cnt = gap;
    end
    else if (wait_cnt != 0)
      wait_cnt = wait_cnt - 4'h1;
    // a released data line shows the inverse, never the stale byte
    if (wait_cnt == 0 && n_sent < limit)
      host_wr = {1'b1, n_sent[7:0] ^ 8'h5a};
    else if (host_wr.valid)
      host_wr = {1'b0, ~host_wr.data};
    host_more = n_sent < limit;
    rd_cnt = (rd_cnt == gap) ? 4'h0 : rd_cnt + 4'h1;
    host_rd_ready = rd_go && rd_cnt == 0;
  end
endmodule // scsi_host_model

// *** tape_buffer_monitor.sv ***
// port assertions for the tape buffer controller
// assumes one clock domain; bound to every controller instance
`timescale 1ns/1ns
module tape_buffer_monitor
  import tape_buffer_pkg::*;
#(
  parameter int unsigned DEPTH       = BUF_BYTES,
  parameter int unsigned RATE_WINDOW = RATE_WINDOW_CYC,
  parameter int unsigned STREAM_MIN  = STREAM_MIN_BYTES
)(
  input wire logic         ref_clk,
  input wire logic         sys_rst,
  input wire logic         write_dir,
  input wire mode_select_s mode_select,
  input wire logic         space_start,
  input wire logic         end_of_data_mark,
  input wire logic         host_wr_ready,
  input wire logic         host_connected,
  input wire byte_beat_s   host_rd,
  input wire byte_beat_s   tape_wr,
  input wire logic         tape_wr_ready,
  input wire logic         tape_rd_ready,
  input wire logic         tape_motion,
  input wire logic         streaming,
  input wire logic         search_fast,
  input wire logic [6:0]   search_speed,
  input wire logic         mark_stop,
  input wire logic [7:0]   motion_thr,
  input wire logic [7:0]   reconn_thr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // thresholds and buffer ports
  // ==========================================================================
  property p_thr_load;
    mode_select.strobe |=> motion_thr == $past(mode_select.motion_thr)
      && reconn_thr == $past(mode_select.reconn_thr);
  endproperty
  a_thr_load: assert property (p_thr_load) else $error("threshold load missed");
  property p_thr_hold;
    !mode_select.strobe |=> $stable(motion_thr) && $stable(reconn_thr);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold changed unasked");
  property p_wr_gate;
    host_wr_ready |-> write_dir && host_connected;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write ready while disconnected");
  property p_rd_gate;
    tape_rd_ready |-> !write_dir && tape_motion;
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("tape read ready while halted");
  property p_dir_out;
    (tape_wr.valid |-> write_dir) and (host_rd.valid |-> !write_dir);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("output valid in wrong direction");
  property p_wr_hold;
    tape_wr.valid && !tape_wr_ready |=> tape_wr.valid && $stable(tape_wr.data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("stalled tape byte lost");

  // ==========================================================================
  // searching
  // ==========================================================================
  property p_search_go;
    space_start |=> search_fast;
  endproperty
  a_search_go: assert property (p_search_go) else $error("search did not start");
  property p_speed;
    search_speed == (search_fast ? SEARCH_SPEED_X : 7'h00);
  endproperty
  a_speed: assert property (p_speed) else $error("search speed wrong");
  property p_mark_once;
    mark_stop |=> !mark_stop;
  endproperty
  a_mark_once: assert property (p_mark_once) else $error("end mark stop too long");
  property p_mark_cause;
    $rose(mark_stop) |-> $past(end_of_data_mark) && $past(search_fast);
  endproperty
  a_mark_cause: assert property (p_mark_cause) else $error("end mark stop without mark");
  property p_mark_halt;
    mark_stop && !space_start |=> !search_fast;
  endproperty
  a_mark_halt: assert property (p_mark_halt) else $error("search kept running");

  c_mark_stop: cover property (mark_stop);
  c_stream: cover property (streaming && host_wr_ready);
  c_rd_motion: cover property ($rose(tape_motion) && !write_dir);
endmodule // tape_buffer_monitor

bind tape_buffer_threshold_ctrl tape_buffer_monitor #(
  .DEPTH(DEPTH), .RATE_WINDOW(RATE_WINDOW), .STREAM_MIN(STREAM_MIN)
) tape_buffer_monitor_inst (
  .ref_clk, .sys_rst, .write_dir, .mode_select, .space_start, .end_of_data_mark, .host_wr_ready,
  .host_connected, .host_rd, .tape_wr, .tape_wr_ready, .tape_rd_ready, .tape_motion,
  .streaming, .search_fast, .search_speed, .mark_stop, .motion_thr, .reconn_thr
);

// *** tape_buffer_pkg.sv ***
// shared constants and carrier types for the tape data buffer controller
// assumes a single 25 mhz clock domain shared with the initiator and tape logic
package tape_buffer_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ            = 25000000;
  localparam int unsigned RATE_WINDOW_US    = 1000;
  localparam int unsigned RATE_WINDOW_CYC   = (CLK_HZ / 1000000) * RATE_WINDOW_US;
  localparam int unsigned STREAM_MIN_KBPS   = 500;
  localparam int unsigned STREAM_MIN_BYTES  = (STREAM_MIN_KBPS * RATE_WINDOW_US) / 1000;

  // ==========================================================================
  // buffer geometry and threshold units
  // ==========================================================================
  localparam int unsigned BUF_BYTES         = 1048576;
  localparam int unsigned UNIT_SHIFT_STD    = 12;
  localparam int unsigned UNIT_SHIFT_LEGACY = 10;
  localparam int unsigned LEGACY_CAP_SHIFT  = 2;
  localparam logic [7:0]  MOTION_THR_RESET  = 8'h80;
  localparam logic [7:0]  RECONN_THR_RESET  = 8'h80;
  localparam logic [6:0]  SEARCH_SPEED_X    = 7'h4b;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_s;

  typedef struct packed {
    logic       strobe;
    logic [7:0] motion_thr;
    logic [7:0] reconn_thr;
  } mode_select_s;

endpackage

// *** tape_buffer_threshold_ctrl.sv ***
// buffer between initiator and tape with motion and reconnect thresholds
// assumes host and tape ports are logic on ref_clk, so no synchronisers;
// direction and format change only while the buffer is empty
`timescale 1ns/1ns

// How it works
// R1: one megabyte buffer serves writes and reads
// R2: streaming at 500 KB/s, else start/stop
// R3: motion threshold, 4 KB units, resets 80h
// R4: start/stop write starts above motion threshold
// R5: write drains to empty; restart above threshold/flush
// R6: legacy format: quarter buffer, 1 KB units
// R7: start/stop read starts when free exceeds threshold
// R8: read fills to full; restart above threshold
// R9: reconnect threshold, 4 KB units, resets 80h
// R10: streaming write disconnects on full, keeps writing
// R11: streaming write reconnects when free exceeds threshold
// R12: accept until full or done, then drain
// R13: streaming read disconnects on empty, keeps reading
// R14: streaming read reconnects above threshold, until empty
// R15: directory option allows two end-of-data marks
// R16: skip first mark if before first filemark
// R17: locate or space searches at 75x speed
// R18: initiator records positions for its directory
// R19: compare scaled threshold on every level change
module tape_buffer_threshold_ctrl
  import tape_buffer_pkg::*;
#(
  parameter int unsigned DEPTH           = BUF_BYTES,
  parameter int unsigned RATE_WINDOW     = RATE_WINDOW_CYC,
  parameter int unsigned STREAM_MIN      = STREAM_MIN_BYTES
)(
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         write_dir,
  input  wire logic         legacy_fmt,
  input  wire logic         dir_support,
  input  wire mode_select_s mode_select,
  input  wire logic         flush_req,
  input  wire byte_beat_s   host_wr,
  output logic              host_wr_ready,
  input  wire logic         host_more,
  output byte_beat_s        host_rd,
  input  wire logic         host_rd_ready,
  output logic              host_connected,
  output byte_beat_s        tape_wr,
  input  wire logic         tape_wr_ready,
  input  wire byte_beat_s   tape_rd,
  output logic              tape_rd_ready,
  output logic              tape_motion,
  output logic              streaming,
  input  wire logic         space_start,
  input  wire logic         space_done,
  input  wire logic         end_of_data_mark,
  input  wire logic         filemark_seen,
  output logic              search_fast,
  output logic [6:0]        search_speed,
  output logic              mark_stop,
  output logic [7:0]        motion_thr,
  output logic [7:0]        reconn_thr
);

  // ==========================================================================
  // sizes and elaboration checks
  // ==========================================================================
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = AW + 1;
  localparam int unsigned CW = $clog2(RATE_WINDOW + 1);
  localparam int unsigned BW = $clog2(RATE_WINDOW + 1) + 1;

  generate
    if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < (256 << UNIT_SHIFT_STD))
    begin : g_bad_depth
      $error("DEPTH must be a power of two holding 255 threshold units");
    end
    if (RATE_WINDOW < 2 || STREAM_MIN > RATE_WINDOW)
    begin : g_bad_window
      $error("rate window must be at least 2 and not below STREAM_MIN");
    end
  endgenerate

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [LW-1:0] level;
    logic [7:0]    motion_thr;
    logic [7:0]    reconn_thr;
    logic          moving;
    logic          connected;
    logic          flushing;
    logic          streaming;
    logic [CW-1:0] win_cnt;
    logic [BW-1:0] byte_cnt;
    logic [1:0]    out_cnt;
    logic [7:0]    out_e0;
    logic [7:0]    out_e1;
    logic          spacing;
    logic          fm_passed;
    logic          mark_skipped;
    logic          mark_stop;
  } state_s;

  state_s        s;
  state_s        next_s;
  logic [7:0]    mem [DEPTH];

  // ==========================================================================
  // combinational terms
  // ==========================================================================
  logic [LW-1:0] cap;
  logic [LW-1:0] free_space;
  logic [LW-1:0] motion_bytes;
  logic [LW-1:0] reconn_bytes;
  logic          full;
  logic          empty;
  byte_beat_s    in_beat;
  logic          in_ready;
  logic          in_take;
  logic          drain_en;
  logic          push;
  logic          out_ready;
  logic          pull;
  logic [1:0]    slot;

  always_comb
  begin
    // legacy format uses a quarter of the buffer with 1 KB threshold units
    if (legacy_fmt)                                                    // see R6
    begin
      cap          = LW'(DEPTH >> LEGACY_CAP_SHIFT);
      motion_bytes = LW'(s.motion_thr) << UNIT_SHIFT_LEGACY;
      reconn_bytes = LW'(s.reconn_thr) << UNIT_SHIFT_LEGACY;
    end
    else
    begin
      cap          = LW'(DEPTH);                                       // see R1
      motion_bytes = LW'(s.motion_thr) << UNIT_SHIFT_STD;              // see R3
      reconn_bytes = LW'(s.reconn_thr) << UNIT_SHIFT_STD;              // see R9
    end
    full       = (s.level >= cap);
    empty      = (s.level == '0);
    free_space = full ? '0 : (cap - s.level);

    // filling side: initiator on writes, tape on reads
    in_beat  = write_dir ? host_wr : tape_rd;                          // see R1
    in_ready = !full && (write_dir ? s.connected : s.moving);
    in_take  = in_beat.valid && in_ready;

    // draining side: tape on writes, initiator on reads
    drain_en  = write_dir ? s.moving : s.connected;
    push      = !empty && drain_en && (s.out_cnt != 2'd2);
    out_ready = write_dir ? tape_wr_ready : host_rd_ready;
    pull      = (s.out_cnt != 2'd0) && out_ready;
    slot      = s.out_cnt - {1'b0, pull};
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    next_s = s;

    if (mode_select.strobe)
    begin
      next_s.motion_thr = mode_select.motion_thr;                      // see R3
      next_s.reconn_thr = mode_select.reconn_thr;                      // see R9
    end

    // buffer pointers and occupancy, re-compared every cycle
    if (in_take)
    begin
      next_s.wr_ptr = s.wr_ptr + AW'(1);
    end
    if (push)
    begin
      next_s.rd_ptr = s.rd_ptr + AW'(1);
    end
    next_s.level = s.level + LW'(in_take) - LW'(push);                 // see R19

    // two-entry output buffer so a stalled receiver loses no byte
    next_s.out_cnt = s.out_cnt + {1'b0, push} - {1'b0, pull};
    if (pull)
    begin
      next_s.out_e0 = s.out_e1;
    end
    if (push)
    begin
      if (slot == 2'd0)
      begin
        next_s.out_e0 = mem[s.rd_ptr];
      end
      else
      begin
        next_s.out_e1 = mem[s.rd_ptr];
      end
    end

    // initiator rate over a fixed window picks streaming or start/stop
    if (s.win_cnt == CW'(RATE_WINDOW - 1))
    begin
      next_s.win_cnt   = '0;
      next_s.byte_cnt  = '0;
      next_s.streaming = (s.byte_cnt + BW'(write_dir ? in_take : pull))
                         >= BW'(STREAM_MIN);                           // see R2
    end
    else
    begin
      next_s.win_cnt  = s.win_cnt + CW'(1);
      next_s.byte_cnt = s.byte_cnt + BW'(write_dir ? in_take : pull);
    end

    // a flush request holds until the buffer has drained
    if (flush_req && write_dir)
    begin
      next_s.flushing = 1'b1;
    end
    else if (empty && !in_take)
    begin
      next_s.flushing = 1'b0;
    end

    // tape motion
    if (write_dir)
    begin
      if (s.moving)
      begin
        next_s.moving = !(next_s.level == '0);                         // see R5
      end
      else if (s.streaming)
      begin
        next_s.moving = !empty;                                        // see R10
      end
      else
      begin
        next_s.moving = (s.level > motion_bytes)
                        || ((s.flushing || flush_req) && !empty);      // see R4 R5
      end
    end
    else
    begin
      if (s.moving)
      begin
        next_s.moving = !full;                                         // see R8
      end
      else if (s.streaming)
      begin
        next_s.moving = !full;                                         // see R13
      end
      else
      begin
        next_s.moving = (free_space > motion_bytes);                   // see R7 R8
      end
    end

    // initiator connection
    if (write_dir)
    begin
      if (!s.streaming)
      begin
        next_s.connected = !full;
      end
      else if (s.connected)
      begin
        next_s.connected = !(full || (!host_more && !in_take));        // see R10 R12
      end
      else
      begin
        next_s.connected = host_more && (free_space > reconn_bytes);   // see R11
      end
    end
    else
    begin
      if (!s.streaming)
      begin
        next_s.connected = !empty || (s.out_cnt != 2'd0);
      end
      else if (s.connected)
      begin
        next_s.connected = !(empty && (s.out_cnt == 2'd0));            // see R13 R14
      end
      else
      begin
        next_s.connected = (s.level > reconn_bytes);                   // see R14
      end
    end

    // high-speed search and end-of-data handling while spacing
    next_s.mark_stop = 1'b0;
    if (space_start)
    begin
      next_s.spacing     = 1'b1;                                       // see R17
      next_s.fm_passed   = 1'b0;
      next_s.mark_skipped = 1'b0;
    end
    else if (s.spacing)
    begin
      if (filemark_seen)
      begin
        next_s.fm_passed = 1'b1;
      end
      if (space_done)
      begin
        next_s.spacing = 1'b0;
      end
      else if (end_of_data_mark)
      begin
        if (dir_support && !s.fm_passed && !s.mark_skipped)
        begin
          next_s.mark_skipped = 1'b1;                                  // see R15 R16
        end
        else
        begin
          next_s.mark_stop = 1'b1;
          next_s.spacing  = 1'b0;
        end
      end
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s            <= '0;
      s.motion_thr <= MOTION_THR_RESET;                                // see R3
      s.reconn_thr <= RECONN_THR_RESET;                                // see R9
    end
    else
    begin
      s <= next_s;
    end
  end

  // buffer storage has no reset; contents are only read behind the level
  always_ff @(posedge ref_clk)
  begin
    if (in_take)
    begin
      mem[s.wr_ptr] <= in_beat.data;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_comb
  begin
    host_wr_ready  = write_dir && in_ready;
    tape_rd_ready  = !write_dir && in_ready;
    host_rd.valid  = !write_dir && (s.out_cnt != 2'd0);
    host_rd.data   = s.out_e0;
    tape_wr.valid  = write_dir && (s.out_cnt != 2'd0);
    tape_wr.data   = s.out_e0;
    host_connected = s.connected;
    tape_motion    = s.moving;
    streaming      = s.streaming;
    search_fast    = s.spacing;
    search_speed   = s.spacing ? SEARCH_SPEED_X : 7'h00;               // see R17
    mark_stop      = s.mark_stop;
    motion_thr     = s.motion_thr;
    reconn_thr     = s.reconn_thr;
  end

endmodule // tape_buffer_threshold_ctrl

// *** tape_buffer_threshold_ctrl_tb_top.sv ***
// self-checking bench for the tape buffer controller
// assumes the monitor is bound and the initiator model sits on the host side
`timescale 1ns/1ns
module tape_buffer_threshold_ctrl_tb_top;
  import tape_buffer_pkg::*;
  logic         ref_clk, sys_rst, write_dir, legacy_fmt, dir_support, flush_req, host_more;
  logic         host_wr_ready, host_rd_ready, host_connected, tape_wr_ready, tape_rd_ready;
  logic         tape_motion, streaming, space_start, space_done, end_of_data_mark, filemark_seen;
  logic         search_fast, mark_stop, rd_go, tr_take;
  logic [6:0]   search_speed;
  logic [7:0]   motion_thr, reconn_thr;
  logic [3:0]   gap;
  logic [15:0]  limit, n_sent, n_tw;
  mode_select_s mode_select;
  byte_beat_s   host_wr, host_rd, tape_wr, tape_rd;
  logic [7:0]   rdq[$];
  int           errors, total_checks, cycles, rd_feed;

  tape_buffer_threshold_ctrl #(.RATE_WINDOW(20), .STREAM_MIN(10)) tape_buffer_threshold_ctrl_inst (
    .ref_clk, .sys_rst, .write_dir, .legacy_fmt, .dir_support, .mode_select, .flush_req, .host_wr,
    .host_wr_ready, .host_more, .host_rd, .host_rd_ready, .host_connected, .tape_wr, .tape_wr_ready,
    .tape_rd, .tape_rd_ready, .tape_motion, .streaming, .space_start, .space_done, .end_of_data_mark,
    .filemark_seen, .search_fast, .search_speed, .mark_stop, .motion_thr, .reconn_thr);
  scsi_host_model scsi_host_model_inst (.ref_clk, .limit, .gap, .rd_go, .host_wr_ready, .host_wr,
    .host_more, .host_rd_ready, .n_sent);

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // byte pattern the initiator model sends, by position in the stream
  function automatic logic [15:0] wr_pattern(input logic [15:0] n);
    return {8'h00, n[7:0] ^ 8'h5a};
  endfunction

  task tally_and_finish();
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk) #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task automatic send(input int n);
    limit = limit + 16'(n);
    for (int i = 0; i < 9000 && n_sent != limit; i++) tick(1);
  endtask

  task automatic drained(input int n);
    for (int i = 0; i < 3000 && n_tw != 16'(n); i++) tick(1);
    tick(3);
    check("tape_wr count", n_tw, 16'(n));
    check("tape_motion", tape_motion, 0);
  endtask

  task automatic wait_motion();
    for (int i = 0; i < 4 && tape_motion !== 1'b1; i++) tick(1);
  endtask

  task automatic space_run(input logic dir, input logic fm, input int eods);
    dir_support = dir;
    pulse(space_start);
    check("search_fast", search_fast, 1);
    check("search_speed", search_speed, 16'h004b);
    if (fm)
      pulse(filemark_seen);
    for (int i = 1; i < eods; i++)
    begin
      pulse(end_of_data_mark);
      check("skip mark_stop", mark_stop, 0);
      tick(1);
      check("skip search_fast", search_fast, 1);
    end
    if (eods == 0)
      pulse(space_done);
    else
      pulse(end_of_data_mark);
    check("mark_stop", mark_stop, 16'(eods != 0));
    tick(1);
    check("search ended", search_fast, 0);
  endtask

  // ==========================================================================
  // tape side: random stalls, random read bytes, order checks
  // ==========================================================================
  always @(negedge ref_clk)
  begin
    tr_take = tape_rd.valid && tape_rd_ready;
    if (tr_take)
      rdq.push_back(tape_rd.data);
    if (tape_wr.valid && tape_wr_ready)
    begin
      check("tape_wr", tape_wr.data, wr_pattern(n_tw));
      n_tw++;
    end
    if (host_rd.valid && host_rd_ready)
      check("host_rd", host_rd.data, rdq.pop_front());
    @(posedge ref_clk);
    #1;
    tape_wr_ready = $urandom_range(3) != 0;
    if (rd_feed != 0 && (tr_take || !tape_rd.valid))
    begin
      tape_rd = {1'b1, 8'($urandom)};
      rd_feed--;
    end
    else if (tr_take)
      tape_rd = {1'b0, ~tape_rd.data};
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(12566));
    {sys_rst, write_dir, legacy_fmt} = 3'b111;
    {dir_support, flush_req, space_start, space_done, end_of_data_mark, filemark_seen, rd_go} = '0;
    {mode_select, limit, n_tw, tape_rd, tape_wr_ready, rd_feed} = '0;
    gap = 4'h3;
    tick(12);
    sys_rst = 1'b0;
    tick(1);
    check("motion_thr", motion_thr, 16'h0080);
    check("reconn_thr", reconn_thr, 16'h0080);
    mode_select = '{1'b1, 8'h01, 8'h01};
    tick(1);
    mode_select.strobe = 1'b0;
    tick(1);
    check("motion_thr", motion_thr, 16'h0001);
    check("reconn_thr", reconn_thr, 16'h0001);
    // slow initiator, legacy units: one kilobyte must be exceeded
    send(1024);
    tick(8);
    check("tape_motion", tape_motion, 0);
    check("streaming", streaming, 0);
    send(1);
    wait_motion();
    check("tape_motion", tape_motion, 1);
    drained(1025);
    send(10);
    tick(8);
    check("tape_motion", tape_motion, 0);
    pulse(flush_req);
    wait_motion();
    check("flush motion", tape_motion, 1);
    drained(1035);
    // full-rate initiator selects streaming
    gap = 4'h0;
    limit = limit + 16'd500;
    for (int i = 0; i < 100 && streaming !== 1'b1; i++) tick(1);
    check("streaming", streaming, 1);
    send(0);
    tick(2);
    check("host_connected", host_connected, 0);
    check("host_wr_ready", host_wr_ready, 0);
    drained(1535);
    // start/stop read keeps moving until full, not until empty
    {legacy_fmt, write_dir, rd_go} = 3'b001;
    gap = 4'h3;
    rd_feed = 64;
    wait_motion();
    check("read motion", tape_motion, 1);
    for (int i = 0; i < 2000 && (rd_feed != 0 || tape_rd.valid || rdq.size() != 0); i++) tick(1);
    check("read pending", 16'(rdq.size()), 0);
    check("read motion", tape_motion, 1);
    space_run(1'b1, 1'b0, 2);
    space_run(1'b0, 1'b0, 1);
    space_run(1'b1, 1'b1, 1);
    space_run(1'b1, 1'b0, 0);
    tally_and_finish();
  end
endmodule // tape_buffer_threshold_ctrl_tb_top
